// File: design/fpr_pkg.sv
package fpr_pkg;
    // Register byte offsets on the AXI4-Lite bus
    localparam int AXI_AW = 12;
    localparam logic [11:0] PROT_OFS = 12'h000;
    localparam logic [11:0] STAT_OFS = 12'h004;
    localparam logic [11:0] MASK_OFS = 12'h008;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Field positions of flash_protection_config, and VIOL_BIT of the status and mask registers
    localparam int POPEN_BIT = 7;
    localparam int SPARE_BIT = 6;
    localparam int HDIS_BIT = 5;
    localparam int HS_MSB = 4;
    localparam int HS_LSB = 3;
    localparam int LDIS_BIT = 2;
    localparam int LS_MSB = 1;
    localparam int LS_LSB = 0;
    localparam int VIOL_BIT = 0;

    // Until the boot byte arrives the whole array is shielded
    localparam logic [7:0] PROT_RST = 8'h24;
    localparam logic [15:0] BOOT_ADDR = 16'hFF0D;
    localparam logic [15:0] LO_BASE = 16'h4000;

    typedef enum logic {FPR_LOAD, FPR_RUN} fpr_state_e;

    function automatic logic [15:0] fpr_hi_start(input logic [1:0] sz);
        case (sz)
            2'h0: fpr_hi_start = 16'hF800;
            2'h1: fpr_hi_start = 16'hF000;
            2'h2: fpr_hi_start = 16'hE000;
            default: fpr_hi_start = 16'hC000;
        endcase
    endfunction

    function automatic logic [15:0] fpr_lo_end(input logic [1:0] sz);
        case (sz)
            2'h0: fpr_lo_end = 16'h41FF;
            2'h1: fpr_lo_end = 16'h43FF;
            2'h2: fpr_lo_end = 16'h47FF;
            default: fpr_lo_end = 16'h4FFF;
        endcase
    endfunction

    // True when a program or erase at addr falls in a protected area
    function automatic logic fpr_prot_hit(input logic [7:0] cfg, input logic [15:0] addr);
        logic hw;
        logic lw;
        hw = !cfg[HDIS_BIT] && (addr >= fpr_hi_start(cfg[HS_MSB:HS_LSB]));
        lw = !cfg[LDIS_BIT] && (addr >= LO_BASE) && (addr <= fpr_lo_end(cfg[LS_MSB:LS_LSB]));
        fpr_prot_hit = cfg[POPEN_BIT] ? (hw || lw) : !(hw || lw);
    endfunction

    // True when the protected set of n contains that of o, for an n whose bit 7 is not set while that of o is clear
    function automatic logic fpr_grows(input logic [7:0] o, input logic [7:0] n);
        logic [15:0] ohs;
        logic [15:0] nhs;
        logic [15:0] ole;
        logic [15:0] nle;
        ohs = fpr_hi_start(o[HS_MSB:HS_LSB]);
        nhs = fpr_hi_start(n[HS_MSB:HS_LSB]);
        ole = fpr_lo_end(o[LS_MSB:LS_LSB]);
        nle = fpr_lo_end(n[LS_MSB:LS_LSB]);
        if (n[POPEN_BIT]) begin
            fpr_grows = (o[HDIS_BIT] || (!n[HDIS_BIT] && nhs <= ohs))
                && (o[LDIS_BIT] || (!n[LDIS_BIT] && nle >= ole));
        end else if (o[POPEN_BIT]) begin
            fpr_grows = (n[HDIS_BIT] || o[HDIS_BIT]) && (n[LDIS_BIT] || o[LDIS_BIT]);
        end else begin
            fpr_grows = (n[HDIS_BIT] || (!o[HDIS_BIT] && nhs >= ohs))
                && (n[LDIS_BIT] || (!o[LDIS_BIT] && nle <= ole));
        end
    endfunction
endpackage

// File: design/fpr_top.sv
// How it works
// RULE1: Software should leave the spare bit 6 erased; it is kept for later use.
// RULE2: High disable bit 5 at 0 makes a window at the top of the map.
// RULE3: Low disable bit 2 at 0 makes a window at the bottom of the map.
// RULE4: High size bits 4..3 take writes only while the high disable bit is set.
// RULE5: Low size bits 1..0 take writes only while the low disable bit is set.
// RULE6: High window ends at FFFF, starts at F800, F000, E000 or C000 by size.
// RULE7: Low window starts at 4000, ends at 41FF, 43FF, 47FF or 4FFF by size.
// RULE8: Open polarity 1 shields enabled windows only; both disabled means nothing shielded.
// RULE9: Open polarity 0 shields all but enabled windows; both disabled shields everything.
// RULE10: After boot software may rewrite the setting, provided protection only grows.
// RULE11: Only changes that add protection are legal transitions.
// RULE12: An illegal transition write is dropped whole; every field stays.
// RULE13: Reading the protection register returns the setting being enforced.
// RULE14: Open polarity bit 7 may only go from 1 to 0.
// RULE15: At reset the register loads from the flash byte at FF0D.
// RULE16: Program or erase into a shielded area is refused and sets the violation flag.
// RULE17: Mass erase only when polarity and both disable bits are 1, else violation.
// RULE18: Legal moves are those whose protected set is a superset of the current.
// RULE19: Each request address is checked against the windows in its accept cycle.
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module fpr_top
    import fpr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [AXI_AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [AXI_AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic boot_rd_req,
    output logic [15:0] boot_rd_addr,
    input wire logic boot_rd_valid,
    input wire logic [7:0] boot_rd_data,
    input wire logic req_valid,
    input wire logic [15:0] req_addr,
    input wire logic req_mass,
    output logic req_done,
    output logic req_viol,
    output logic [7:0] prot_cfg,
    output logic irq
);
    fpr_state_e state_r, state_nxt;
    logic [7:0] prot_r, prot_nxt;
    logic [7:0] cand;
    logic viol_flag_r, viol_flag_nxt;
    logic mask_r, mask_nxt;
    logic irq_r, irq_nxt;
    logic done_r, done_nxt;
    logic viol_r, viol_nxt;
    logic boot_req_r, boot_req_nxt;
    // Boot address sits in a flop so that every output leaves a register
    logic [15:0] boot_addr_r;
    logic aw_held_r, aw_held_nxt;
    logic w_held_r, w_held_nxt;
    logic [AXI_AW-1:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic awready_r, awready_nxt;
    logic wready_r, wready_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic arready_r, arready_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic clr;

    always_comb begin
        state_nxt = state_r;
        prot_nxt = prot_r;
        cand = prot_r;
        mask_nxt = mask_r;
        boot_req_nxt = 1'b0;
        done_nxt = 1'b0;
        viol_nxt = 1'b0;
        clr = 1'b0;
        aw_held_nxt = aw_held_r;
        w_held_nxt = w_held_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        case (state_r)
            FPR_LOAD: begin
                boot_req_nxt = !boot_rd_valid;
                if (boot_rd_valid) begin
                    prot_nxt = boot_rd_data; // RULE15
                    state_nxt = FPR_RUN;
                end
            end
            FPR_RUN: begin
                // Requests during boot load get no answer at all
                if (req_valid) begin
                    if (req_mass) begin
                        viol_nxt = !(prot_r[POPEN_BIT] && prot_r[HDIS_BIT]
                            && prot_r[LDIS_BIT]); // RULE17
                    end else begin
                        viol_nxt = fpr_prot_hit(prot_r, req_addr); // RULE16 RULE19 RULE8 RULE9
                    end
                    done_nxt = !viol_nxt;
                end
            end
            default: state_nxt = FPR_LOAD;
        endcase
        if (bvalid_r && bready) begin
            bvalid_nxt = 1'b0;
        end
        if (awvalid && awready_r) begin
            aw_held_nxt = 1'b1;
            awaddr_nxt = awaddr;
        end
        if (wvalid && wready_r) begin
            w_held_nxt = 1'b1;
            wdata_nxt = wdata;
            wstrb_nxt = wstrb;
        end
        if (aw_held_r && w_held_r && !bvalid_r) begin
            aw_held_nxt = 1'b0;
            w_held_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = RESP_OKAY;
            if ({awaddr_r[AXI_AW-1:2], 2'b00} == PROT_OFS) begin
                cand[POPEN_BIT] = prot_r[POPEN_BIT] & wdata_r[POPEN_BIT]; // RULE14
                cand[SPARE_BIT] = wdata_r[SPARE_BIT]; // RULE1
                cand[HDIS_BIT] = wdata_r[HDIS_BIT];
                cand[LDIS_BIT] = wdata_r[LDIS_BIT];
                if (prot_r[HDIS_BIT]) begin
                    cand[HS_MSB:HS_LSB] = wdata_r[HS_MSB:HS_LSB]; // RULE4
                end
                if (prot_r[LDIS_BIT]) begin
                    cand[LS_MSB:LS_LSB] = wdata_r[LS_MSB:LS_LSB]; // RULE5
                end
                // Boot load owns the register until it finishes
                if (wstrb_r[0] && state_r == FPR_RUN && fpr_grows(prot_r, cand)) begin
                    prot_nxt = cand; // RULE10 RULE11 RULE12 RULE18
                end
            end else if ({awaddr_r[AXI_AW-1:2], 2'b00} == STAT_OFS) begin
                clr = wstrb_r[0] && wdata_r[VIOL_BIT];
            end else if ({awaddr_r[AXI_AW-1:2], 2'b00} == MASK_OFS) begin
                if (wstrb_r[0]) begin
                    mask_nxt = wdata_r[VIOL_BIT];
                end
            end else begin
                bresp_nxt = RESP_SLVERR;
            end
        end
        awready_nxt = !aw_held_nxt && !bvalid_nxt;
        wready_nxt = !w_held_nxt && !bvalid_nxt;
        // A violation in the clearing cycle keeps the flag set
        viol_flag_nxt = (viol_flag_r && !clr) || viol_nxt;
        irq_nxt = viol_flag_nxt && mask_nxt;
        if (rvalid_r && rready) begin
            rvalid_nxt = 1'b0;
        end
        if (arvalid && arready_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = RESP_OKAY;
            rdata_nxt = 32'h0000_0000;
            if ({araddr[AXI_AW-1:2], 2'b00} == PROT_OFS) begin
                rdata_nxt[7:0] = prot_r; // RULE13
            end else if ({araddr[AXI_AW-1:2], 2'b00} == STAT_OFS) begin
                rdata_nxt[VIOL_BIT] = viol_flag_r;
            end else if ({araddr[AXI_AW-1:2], 2'b00} == MASK_OFS) begin
                rdata_nxt[VIOL_BIT] = mask_r;
            end else begin
                rresp_nxt = RESP_SLVERR;
            end
        end
        arready_nxt = !rvalid_nxt;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= FPR_LOAD;
            prot_r <= PROT_RST;
            viol_flag_r <= 1'b0;
            mask_r <= 1'b0;
            irq_r <= 1'b0;
            done_r <= 1'b0;
            viol_r <= 1'b0;
            boot_req_r <= 1'b0;
            boot_addr_r <= BOOT_ADDR;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else begin
            state_r <= state_nxt;
            prot_r <= prot_nxt;
            viol_flag_r <= viol_flag_nxt;
            mask_r <= mask_nxt;
            irq_r <= irq_nxt;
            done_r <= done_nxt;
            viol_r <= viol_nxt;
            boot_req_r <= boot_req_nxt;
            boot_addr_r <= BOOT_ADDR;
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign boot_rd_req = boot_req_r;
    assign boot_rd_addr = boot_addr_r;
    assign req_done = done_r;
    assign req_viol = viol_r;
    assign prot_cfg = prot_r;
    assign irq = irq_r;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_popen_no_rise: assert property ( // RULE14
        state_r == FPR_RUN && $past(state_r) == FPR_RUN |-> !$rose(prot_r[POPEN_BIT]))
        else $error("open polarity bit rose in run");
    a_hsize_locked: assert property ( // RULE4
        state_r == FPR_RUN && !prot_r[HDIS_BIT] |=> $stable(prot_r[HS_MSB:HS_LSB]))
        else $error("high size changed while window enabled");
    a_lsize_locked: assert property ( // RULE5
        state_r == FPR_RUN && !prot_r[LDIS_BIT] |=> $stable(prot_r[LS_MSB:LS_LSB]))
        else $error("low size changed while window enabled");
    a_boot_load_byte: assert property ( // RULE15
        state_r == FPR_LOAD && boot_rd_valid |=> prot_r == $past(boot_rd_data) && state_r == FPR_RUN)
        else $error("boot byte not loaded");
    a_mass_refused: assert property ( // RULE17
        state_r == FPR_RUN && req_valid && req_mass
        && !(prot_r[POPEN_BIT] && prot_r[HDIS_BIT] && prot_r[LDIS_BIT])
        |=> req_viol && !req_done && viol_flag_r)
        else $error("mass erase not refused");
    a_full_protect: assert property ( // RULE9
        state_r == FPR_RUN && req_valid && !prot_r[POPEN_BIT] && prot_r[HDIS_BIT]
        && prot_r[LDIS_BIT] |=> req_viol)
        else $error("fully protected array accepted a request");
    a_open_array: assert property ( // RULE8
        state_r == FPR_RUN && req_valid && prot_r[POPEN_BIT] && prot_r[HDIS_BIT]
        && prot_r[LDIS_BIT] |=> req_done && !req_viol)
        else $error("unprotected array refused a request");
    a_high_window: assert property ( // RULE6 RULE2
        state_r == FPR_RUN && req_valid && !req_mass && prot_r[POPEN_BIT] && !prot_r[HDIS_BIT]
        && req_addr >= fpr_hi_start(prot_r[HS_MSB:HS_LSB]) |=> req_viol)
        else $error("high window write not refused");
    a_low_window: assert property ( // RULE7 RULE3
        state_r == FPR_RUN && req_valid && !req_mass && !prot_r[POPEN_BIT] && !prot_r[LDIS_BIT]
        && req_addr == LO_BASE |=> req_done)
        else $error("open low window refused a request");
    a_irq_level: assert property (
        ##1 irq == (viol_flag_r && mask_r))
        else $error("interrupt does not follow flag and mask");
    a_viol_sets_flag: assert property ( // RULE16
        req_viol |-> viol_flag_r && !req_done)
        else $error("refused request did not set the violation flag");

    c_prot_change: cover property (state_r == FPR_RUN ##1 $changed(prot_r));
    c_violation: cover property (req_viol ##1 irq);
    c_mass_ok: cover property (req_valid && req_mass && state_r == FPR_RUN ##1 req_done);
    c_boot_load: cover property (state_r == FPR_LOAD && boot_rd_valid);
    c_flag_clear: cover property (clr && viol_flag_r ##1 !viol_flag_r);
endmodule
`default_nettype wire

// File: test/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb
    import fpr_pkg::*;
;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, boot_rd_req, boot_rd_valid;
    logic req_valid, req_mass, req_done, req_viol, irq;
    logic [AXI_AW-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    logic [15:0] boot_rd_addr, req_addr;
    logic [7:0] boot_rd_data, prot_cfg, d, cand;
    int err_total, total_checks;
    bit [7:0] cfg_m;
    bit viol_m, mask_m;
    // Both ends of each uniform region (only the top of the lowest), so region-wise checks cover the whole map
    bit [15:0] pts [19] = '{16'h3FFF, 16'h4000, 16'h41FF, 16'h4200, 16'h43FF, 16'h4400,
        16'h47FF, 16'h4800, 16'h4FFF, 16'h5000, 16'hBFFF, 16'hC000, 16'hDFFF, 16'hE000,
        16'hEFFF, 16'hF000, 16'hF7FF, 16'hF800, 16'hFFFF};
    bit [15:0] hs_t [4] = '{16'hF800, 16'hF000, 16'hE000, 16'hC000};
    bit [15:0] le_t [4] = '{16'h41FF, 16'h43FF, 16'h47FF, 16'h4FFF};

    fpr_top uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .boot_rd_req(boot_rd_req), .boot_rd_addr(boot_rd_addr), .boot_rd_valid(boot_rd_valid),
        .boot_rd_data(boot_rd_data), .req_valid(req_valid), .req_addr(req_addr),
        .req_mass(req_mass), .req_done(req_done), .req_viol(req_viol), .prot_cfg(prot_cfg),
        .irq(irq));

    always #25 aclk = ~aclk;

    function automatic bit hit_m(bit [7:0] c, bit [15:0] a);
        bit hw, lw;
        hw = !c[5] && a >= hs_t[c[4:3]];
        lw = !c[2] && a >= 16'h4000 && a <= le_t[c[1:0]];
        return c[7] ? (hw || lw) : !(hw || lw);
    endfunction

    function automatic bit grows_m(bit [7:0] o, bit [7:0] n);
        foreach (pts[i]) if (hit_m(o, pts[i]) && !hit_m(n, pts[i])) return 0;
        return 1;
    endfunction

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic axi_wr(logic [11:0] a, logic [31:0] dt, output logic [1:0] r);
        bit ad, wd, bd;
        @(posedge aclk);
        awaddr <= a; wdata <= dt; wstrb <= 4'hF; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        // Only bvalid or the watchdog ends this wait
        while (!bd) begin
            @(posedge aclk);
            if (!ad && awready === 1'b1) begin ad = 1; awvalid <= 1'b0; end
            if (!wd && wready === 1'b1) begin wd = 1; wvalid <= 1'b0; end
            if (bvalid === 1'b1) begin bd = 1; r = bresp; end
        end
        bready <= 1'b0;
        chk("aw and w taken by bvalid", 1, ad && wd);
    endtask

    task automatic axi_rd(logic [11:0] a, output logic [31:0] dt, output logic [1:0] r);
        bit ad, rdn;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        while (!rdn) begin
            @(posedge aclk);
            if (!ad && arready === 1'b1) begin ad = 1; arvalid <= 1'b0; end
            if (rvalid === 1'b1) begin rdn = 1; dt = rdata; r = rresp; end
        end
        rready <= 1'b0;
        chk("ar taken by rvalid", 1, ad);
    endtask

    task automatic do_req(logic [15:0] a, logic m, bit run);
        bit ok;
        @(posedge aclk);
        req_valid <= 1'b1; req_addr <= a; req_mass <= m;
        @(posedge aclk);
        req_valid <= 1'b0;
        @(posedge aclk);
        ok = m ? (cfg_m[7] && cfg_m[5] && cfg_m[2]) : !hit_m(cfg_m, a);
        if (run && !ok) viol_m = 1;
        chk("req_done", run && ok, req_done);
        chk("req_viol", run && !ok, req_viol);
        chk("irq", viol_m && mask_m, irq);
    endtask

    task automatic do_reset(logic [7:0] b);
        @(posedge aclk);
        aresetn <= 1'b0;
        // Reset clears flag and mask, so the model must forget them here
        viol_m = 0;
        mask_m = 0;
        repeat (8) @(posedge aclk);
        chk("prot_cfg in reset", PROT_RST, prot_cfg);
        aresetn <= 1'b1;
        // Writes and requests ahead of the boot byte must leave no trace
        axi_wr(PROT_OFS, 32'hFF, rs);
        chk("early bresp", RESP_OKAY, rs);
        axi_rd(PROT_OFS, rd, rs);
        chk("early prot", PROT_RST, rd);
        do_req(16'h0000, 1'b1, 0);
        for (int i = 0; i < 20 && boot_rd_req !== 1'b1; i++) @(posedge aclk);
        chk("boot_rd_req", 1, boot_rd_req);
        chk("boot_rd_addr", BOOT_ADDR, boot_rd_addr);
        boot_rd_valid <= 1'b1; boot_rd_data <= b;
        @(posedge aclk);
        boot_rd_valid <= 1'b0;
        cfg_m = b;
        axi_rd(PROT_OFS, rd, rs);
        chk("boot prot", {24'h0, b}, rd);
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #3000000;
        err_total++;
        summarize();
    end

    initial begin
        aclk = 0; aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
        awaddr = '0; araddr = '0; wdata = '0; wstrb = '0; boot_rd_valid = 0;
        boot_rd_data = '0; req_valid = 0; req_addr = '0; req_mass = 0;
        void'($urandom(91));
        // Second and third boots are resets in mid-run
        for (int k = 0; k < 3; k++) begin
            d = (k == 0) ? 8'hFF : (k == 1) ? 8'h40 : (8'($urandom) | 8'h40);
            do_reset(d);
            axi_wr(12'h00C, 32'h1, rs);
            chk("unmapped bresp", RESP_SLVERR, rs);
            axi_rd(12'h00C, rd, rs);
            chk("unmapped rresp", RESP_SLVERR, rs);
            chk("unmapped rdata", 0, rd);
            repeat (16) begin
                d = 8'($urandom) | 8'h40;
                case ($urandom % 4)
                    0, 1: begin
                        cand = {cfg_m[7] & d[7], d[6:5], cfg_m[5] ? d[4:3] : cfg_m[4:3],
                            d[2], cfg_m[2] ? d[1:0] : cfg_m[1:0]};
                        if (grows_m(cfg_m, cand)) cfg_m = cand;
                        axi_wr(PROT_OFS, {24'h0, d}, rs);
                    end
                    2: begin
                        viol_m = viol_m & !d[0];
                        axi_wr(STAT_OFS, {24'h0, d}, rs);
                    end
                    default: begin
                        mask_m = d[0];
                        axi_wr(MASK_OFS, {24'h0, d}, rs);
                    end
                endcase
                chk("bresp", RESP_OKAY, rs);
                axi_rd(PROT_OFS, rd, rs);
                chk("prot rdata", {24'h0, cfg_m}, rd);
                chk("prot rresp", RESP_OKAY, rs);
                chk("prot_cfg", cfg_m, prot_cfg);
                axi_rd(STAT_OFS, rd, rs);
                chk("status", viol_m, rd);
                axi_rd(MASK_OFS, rd, rs);
                chk("mask", mask_m, rd);
                chk("irq level", viol_m && mask_m, irq);
                repeat (3) begin
                    do_req(($urandom % 2) ? pts[$urandom % 19] : 16'($urandom),
                        ($urandom % 6) == 0, 1);
                end
            end
        end
        summarize();
    end
endmodule
`default_nettype wire
